// File: rtl/pld_cfg.svh
// Constants for the PLL lock detect and holdover block
`ifndef PLD_CFG_SVH
`define PLD_CFG_SVH
`define PLD_AW              8
`define PLD_DW              8
`define PLD_ADDR_ABP        8'h17
`define PLD_ADDR_LDCTL      8'h18
`define PLD_ADDR_RSYNC      8'h19
`define PLD_ADDR_LDSEL      8'h1A
`define PLD_ADDR_MONSEL     8'h1B
`define PLD_ADDR_HOLD       8'h1D
`define PLD_ADDR_STATUS     8'h1F
`define PLD_ADDR_PHERR      8'h20
`define PLD_ABP_RST         8'h00
`define PLD_LDCTL_RST       8'h00
`define PLD_RSYNC_RST       8'h00
`define PLD_LDSEL_RST       8'h00
`define PLD_MONSEL_RST      8'h00
`define PLD_HOLD_RST        8'h00
`define PLD_CNT_LO          5
`define PLD_CNT_HI          6
`define PLD_WIN_BIT         4
`define PLD_DLD_OFF_BIT     3
`define PLD_SYNC_LO         6
`define PLD_SYNC_HI         7
`define PLD_RDLY_LO         0
`define PLD_RDLY_HI         2
`define PLD_NDLY_LO         3
`define PLD_NDLY_HI         5
`define PLD_HOLD_EN0        0
`define PLD_HOLD_EXT        1
`define PLD_HOLD_EN2        2
`define PLD_HOLD_CMP        3
`define PLD_SEL_DLD         6'h01
`define PLD_SEL_ALD_N       6'h02
`define PLD_SEL_ALD_P       6'h03
`define PLD_SEL_CURRENT_SOURCE_LOCK_DETECT       6'h04
`define PLD_SEL_CMP_H       6'h05
`define PLD_SEL_CMP_L       6'h06
`define PLD_LOCK_THR_HI     8'h0C
`define PLD_LOCK_THR_LO     8'h04
`define PLD_UNLOCK_ADD      8'h04
`endif

// File: rtl/pld_pkg.sv
// Types shared by the lock detect and holdover logic
package pld_pkg;
  typedef enum logic [1:0] {
    PLD_HS_RUN,
    PLD_HS_HOLD,
    PLD_HS_WAIT_REF
  } pld_hold_e;
  typedef logic [7:0] pld_byte_t;
endpackage : pld_pkg

// File: rtl/pld_lock_if.sv
// Lock detector connection between the top and the detector
`timescale 1ns/1ps
interface pld_lock_if;
  logic       pfd_event;
  logic [7:0] phase_err;
  logic [7:0] lock_thr;
  logic [7:0] unlock_thr;
  logic [2:0] need_cnt;
  logic       dld_enable;
  logic       locked;
  modport ctl (output pfd_event, phase_err, lock_thr, unlock_thr,
               need_cnt, dld_enable, input locked);
  modport det (input pfd_event, phase_err, lock_thr, unlock_thr,
               need_cnt, dld_enable, output locked);
endinterface : pld_lock_if

// File: rtl/pld_lock_det.sv
// Digital lock detector with lock/unlock hysteresis
`timescale 1ns/1ps
module pld_lock_det #(
  parameter int CW = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Detector side of the lock link
  pld_lock_if.det  lk
);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          lock_r;
  logic          lock_nxt;

  // Count good cycles; one bad cycle past unlock drops lock
  always_comb begin
    cnt_nxt  = cnt_r;
    lock_nxt = lock_r;
    if (!lk.dld_enable) begin
      cnt_nxt  = '0;
      lock_nxt = 1'b0;
    end else if (lk.pfd_event) begin
      if (!lock_r) begin
        if (lk.phase_err < lk.lock_thr) begin
          if (cnt_r != lk.need_cnt[CW-1:0]) begin
            cnt_nxt = cnt_r + 1'b1;
          end
          if (cnt_r + 1'b1 >= lk.need_cnt[CW-1:0]) begin
            lock_nxt = 1'b1;
          end
        end else begin
          cnt_nxt = '0;
        end
      end else if (lk.phase_err > lk.unlock_thr) begin
        lock_nxt = 1'b0;
        cnt_nxt  = '0;
      end
    end
  end

  // Register stage
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_r  <= '0;
      lock_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lk.locked = lock_r;
endmodule : pld_lock_det

// File: rtl/pld_lock_holdover.sv
// PLL lock detect, pin routing, counter resync and holdover control
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_lock_holdover #(
  parameter int CW = 3
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Phase detector edges and measured phase error
  input  wire logic        ref_edge,
  input  wire logic        fb_edge,
  input  wire logic [7:0]  phase_err,
  // Pins from outside
  input  wire logic        resync_pin_n,
  input  wire logic        ld_cmp_in,
  input  wire logic        ald_pulse,
  // Counter resets and delay selects
  output logic             r_cnt_reset,
  output logic             a_cnt_reset,
  output logic             b_cnt_reset,
  output logic      [2:0]  r_delay_sel,
  output logic      [2:0]  n_delay_sel,
  // Charge pump and pins
  output logic             cp_high_z,
  output logic             lock_indicator_pin,
  output logic             lock_indicator_pin_oe,
  output logic             ld_current_on,
  output logic             status_pin,
  output logic             reference_monitor_pin
);
  pld_lock_if lk ();

  pld_pkg::pld_byte_t abp_r, ldctl_r, rsync_r, ldsel_r, monsel_r, hold_r;
  pld_pkg::pld_byte_t abp_nxt, ldctl_nxt, rsync_nxt, ldsel_nxt;
  pld_pkg::pld_byte_t monsel_nxt, hold_nxt, rdata_nxt;
  logic sy1_r, sy2_r, sy3_r;
  logic cm1_r, cm2_r;
  pld_pkg::pld_hold_e hs_r, hs_nxt;
  logic hz_nxt, bres_nxt, rres_nxt, ldo_nxt, ldoe_nxt, ldi_nxt;
  logic st_nxt, mon_nxt;
  logic [2:0] rd_nxt, nd_nxt;
  logic sync_fall, cmp_seen, digital_lock_detect, hold_en, ext_mode;
  logic [7:0] lthr, uthr;

  // Register writes; all enables start cleared, and the cleared off bit leaves the digital lock detector enabled
  always_comb begin
    abp_nxt    = abp_r;
    ldctl_nxt  = ldctl_r;
    rsync_nxt  = rsync_r;
    ldsel_nxt  = ldsel_r;
    monsel_nxt = monsel_r;
    hold_nxt   = hold_r;
    if (reg_write) begin
      unique case (reg_addr)
        `PLD_ADDR_ABP:    abp_nxt    = reg_wdata;
        `PLD_ADDR_LDCTL:  ldctl_nxt  = reg_wdata;
        `PLD_ADDR_RSYNC:  rsync_nxt  = reg_wdata;
        `PLD_ADDR_LDSEL:  ldsel_nxt  = reg_wdata;
        `PLD_ADDR_MONSEL: monsel_nxt = reg_wdata;
        `PLD_ADDR_HOLD:   hold_nxt   = reg_wdata;
        default:          abp_nxt    = abp_r;
      endcase
    end
  end

  // Read data, valid only the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        `PLD_ADDR_ABP:    rdata_nxt = abp_r;
        `PLD_ADDR_LDCTL:  rdata_nxt = ldctl_r;
        `PLD_ADDR_RSYNC:  rdata_nxt = rsync_r;
        `PLD_ADDR_LDSEL:  rdata_nxt = ldsel_r;
        `PLD_ADDR_MONSEL: rdata_nxt = monsel_r;
        `PLD_ADDR_HOLD:   rdata_nxt = hold_r;
        `PLD_ADDR_STATUS: rdata_nxt = {4'h0, cm2_r, cp_high_z,
                                       hs_r != pld_pkg::PLD_HS_RUN, digital_lock_detect};
        `PLD_ADDR_PHERR:  rdata_nxt = phase_err;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  // Thresholds: window bit and backlash width shift the window
  // Worst case 12 + 3 + 4 still fits in eight bits, so no wrap
  always_comb begin
    lthr = ldctl_r[`PLD_WIN_BIT] ? `PLD_LOCK_THR_LO : `PLD_LOCK_THR_HI;
    lthr = lthr + {6'h00, abp_r[1:0]};
    uthr = lthr + `PLD_UNLOCK_ADD;
  end

  // Detector link
  // Either phase detector input counts as one detector cycle
  assign lk.pfd_event  = ref_edge | fb_edge;
  assign lk.phase_err  = phase_err;
  assign lk.lock_thr   = lthr;
  assign lk.unlock_thr = uthr;
  // Counter code 0..3 means 4,5,6,7 good cycles; a leading one is added, no scaling
  assign lk.need_cnt   = {1'b1, ldctl_r[`PLD_CNT_HI:`PLD_CNT_LO]};
  assign lk.dld_enable = !ldctl_r[`PLD_DLD_OFF_BIT];
  assign digital_lock_detect           = lk.locked;

  pld_lock_det #(.CW(CW)) u_det (
    .clock (clock),
    .reset (reset),
    .lk    (lk.det)
  );

  // Resync and comparator pins pass two flops before use; ald_pulse is not synchronised
  // Third flop only forms the falling edge of the synced pin
  assign sync_fall = sy3_r && !sy2_r;
  assign cmp_seen  = hold_r[`PLD_HOLD_CMP] ? cm2_r : 1'b1;
  assign hold_en   = hold_r[`PLD_HOLD_EN0] && hold_r[`PLD_HOLD_EN2];
  assign ext_mode  = hold_r[`PLD_HOLD_EXT];

  // Holdover: enter on pin edge or low comparator, leave on reference edge
  always_comb begin
    hs_nxt   = hs_r;
    bres_nxt = 1'b0;
    unique case (hs_r)
      pld_pkg::PLD_HS_RUN: begin
        if (hold_en && ext_mode && sync_fall) begin
          hs_nxt = pld_pkg::PLD_HS_HOLD;
        end else if (hold_en && !ext_mode && !cmp_seen) begin
          hs_nxt = pld_pkg::PLD_HS_WAIT_REF;
        end
      end
      pld_pkg::PLD_HS_HOLD: begin
        if (!hold_en) begin
          hs_nxt = pld_pkg::PLD_HS_RUN;
        end else if (sy2_r) begin
          hs_nxt = pld_pkg::PLD_HS_WAIT_REF;
        end
      end
      pld_pkg::PLD_HS_WAIT_REF: begin
        if (!hold_en) begin
          hs_nxt = pld_pkg::PLD_HS_RUN;
        end else if (ext_mode && !sy2_r) begin
          hs_nxt = pld_pkg::PLD_HS_HOLD;
        end else if (ref_edge) begin
          hs_nxt   = pld_pkg::PLD_HS_RUN;
          bres_nxt = 1'b1;
        end
      end
      default: begin
        hs_nxt = pld_pkg::PLD_HS_RUN;
      end
    endcase
    // Charge pump floats whenever not running
    hz_nxt = (hs_nxt != pld_pkg::PLD_HS_RUN);
  end

  // Resync reset of R, A and B; off until enabled
  // Suppressed while external holdover owns the pin
  always_comb begin
    rres_nxt = (rsync_r[`PLD_SYNC_HI:`PLD_SYNC_LO] != 2'b00)
               && !sy2_r && !(hold_en && ext_mode);
    rd_nxt   = rsync_r[`PLD_RDLY_HI:`PLD_RDLY_LO];
    nd_nxt   = rsync_r[`PLD_NDLY_HI:`PLD_NDLY_LO];
  end

  // Output pin muxes
  always_comb begin
    ldo_nxt  = 1'b0;
    ldoe_nxt = 1'b1;
    ldi_nxt  = 1'b0;
    unique case (ldsel_r[5:0])
      `PLD_SEL_DLD:   ldo_nxt = digital_lock_detect;
      `PLD_SEL_ALD_N: ldo_nxt = !ald_pulse;
      `PLD_SEL_ALD_P: ldo_nxt = ald_pulse;
      `PLD_SEL_CURRENT_SOURCE_LOCK_DETECT: begin
        ldi_nxt  = digital_lock_detect;
        ldoe_nxt = !digital_lock_detect;
      end
      default:        ldo_nxt = 1'b0;
    endcase
    unique case (abp_r[7:2])
      `PLD_SEL_DLD:   st_nxt = digital_lock_detect;
      `PLD_SEL_CMP_H: st_nxt = cm2_r;
      `PLD_SEL_CMP_L: st_nxt = !cm2_r;
      default:        st_nxt = 1'b0;
    endcase
    unique case (monsel_r[4:0])
      5'(`PLD_SEL_DLD):   mon_nxt = digital_lock_detect;
      5'(`PLD_SEL_CMP_H): mon_nxt = cm2_r;
      5'(`PLD_SEL_CMP_L): mon_nxt = !cm2_r;
      default:            mon_nxt = 1'b0;
    endcase
  end

  // Register file and read data
  always_ff @(posedge clock) begin
    if (reset) begin
      abp_r     <= `PLD_ABP_RST;
      ldctl_r   <= `PLD_LDCTL_RST;
      rsync_r   <= `PLD_RSYNC_RST;
      ldsel_r   <= `PLD_LDSEL_RST;
      monsel_r  <= `PLD_MONSEL_RST;
      hold_r    <= `PLD_HOLD_RST;
      reg_rdata <= 8'h00;
    end else begin
      abp_r     <= abp_nxt;
      ldctl_r   <= ldctl_nxt;
      rsync_r   <= rsync_nxt;
      ldsel_r   <= ldsel_nxt;
      monsel_r  <= monsel_nxt;
      hold_r    <= hold_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // Pin synchronisers; reset to idle levels so no false edge follows
  always_ff @(posedge clock) begin
    if (reset) begin
      sy1_r <= 1'b1;
      sy2_r <= 1'b1;
      sy3_r <= 1'b1;
      cm1_r <= 1'b0;
      cm2_r <= 1'b0;
    end else begin
      sy1_r <= resync_pin_n;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      cm1_r <= ld_cmp_in;
      cm2_r <= cm1_r;
    end
  end

  // Holdover state, counter resets and delay selects
  always_ff @(posedge clock) begin
    if (reset) begin
      hs_r        <= pld_pkg::PLD_HS_RUN;
      cp_high_z   <= 1'b0;
      r_cnt_reset <= 1'b0;
      a_cnt_reset <= 1'b0;
      b_cnt_reset <= 1'b0;
      r_delay_sel <= 3'h0;
      n_delay_sel <= 3'h0;
    end else begin
      hs_r        <= hs_nxt;
      cp_high_z   <= hz_nxt;
      r_cnt_reset <= rres_nxt;
      a_cnt_reset <= rres_nxt;
      // B also clears on holdover release; the prescaler never does
      b_cnt_reset <= bres_nxt | rres_nxt;
      r_delay_sel <= rd_nxt;
      n_delay_sel <= nd_nxt;
    end
  end

  // Pin outputs; the lock pin is driven low out of reset
  always_ff @(posedge clock) begin
    if (reset) begin
      lock_indicator_pin    <= 1'b0;
      lock_indicator_pin_oe <= 1'b1;
      ld_current_on         <= 1'b0;
      status_pin            <= 1'b0;
      reference_monitor_pin <= 1'b0;
    end else begin
      lock_indicator_pin    <= ldo_nxt;
      lock_indicator_pin_oe <= ldoe_nxt;
      ld_current_on         <= ldi_nxt;
      status_pin            <= st_nxt;
      reference_monitor_pin <= mon_nxt;
    end
  end
endmodule : pld_lock_holdover

// File: test/pld_host_model.sv
// Host model that drives the active-low resync pin
`timescale 1ns/1ps
module pld_host_model (
  // Clock
  input  wire logic clock,
  // Bench request to pull the pin low
  input  wire logic hold_req,
  // Resync pin, idles high
  output logic      resync_pin_n
);
  logic pin_nxt;
  // Pin only moves just after an edge, never mid-cycle
  always_comb pin_nxt = ~hold_req;
  // The block, not the host, keeps the counter resets deaf to this pin in external holdover
  always_ff @(posedge clock) resync_pin_n <= pin_nxt;
endmodule : pld_host_model

// File: test/pld_chk_sva.sv
// Port-level checker for the lock detect and holdover block
`timescale 1ns/1ps
module pld_chk (
  // Clock and reset
  input wire logic       clock,
  input wire logic       reset,
  // Watched ports
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       ref_edge,
  input wire logic       resync_pin_n,
  input wire logic       r_cnt_reset,
  input wire logic       a_cnt_reset,
  input wire logic       b_cnt_reset,
  input wire logic       cp_high_z,
  input wire logic       lock_indicator_pin_oe,
  input wire logic       ld_current_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Read data only in its one slot
  chk_rdata_slot: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  chk_cnt_together: assert property (
    r_cnt_reset |-> a_cnt_reset && b_cnt_reset) else $error("resets split");
  chk_rsync_cause: assert property (r_cnt_reset |->
    !$past(resync_pin_n, 2) || !$past(resync_pin_n, 3) ||
    !$past(resync_pin_n, 4)) else $error("counter reset without pin");
  chk_reset_vals: assert property ($fell(reset) |-> !r_cnt_reset &&
    !cp_high_z && !ld_current_on && lock_indicator_pin_oe)
    else $error("bad values after reset");
  chk_hz_hold: assert property (
    cp_high_z && !resync_pin_n |=> cp_high_z) else $error("left hold early");
  chk_hz_release: assert property ($fell(cp_high_z) |->
    $past(ref_edge) || $past(ref_edge, 2)) else $error("release w/o ref");
  chk_bres_pulse: assert property (
    b_cnt_reset && !r_cnt_reset |=> !b_cnt_reset) else $error("long b reset");
  chk_bres_cause: assert property (
    b_cnt_reset && !r_cnt_reset |-> $fell(cp_high_z))
    else $error("b reset not at release");
  // Main scenarios reached
  cov_release: cover property ($fell(cp_high_z));
  cov_current: cover property ($rose(ld_current_on));
  cov_resync: cover property ($rose(r_cnt_reset));
endmodule : pld_chk

bind pld_lock_holdover pld_chk chk_u (.clock(clock), .reset(reset),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .ref_edge(ref_edge),
  .resync_pin_n(resync_pin_n), .r_cnt_reset(r_cnt_reset),
  .a_cnt_reset(a_cnt_reset), .b_cnt_reset(b_cnt_reset),
  .cp_high_z(cp_high_z), .ld_current_on(ld_current_on),
  .lock_indicator_pin_oe(lock_indicator_pin_oe));

// File: test/tb_top.sv
// Self-checking bench for the lock detect and holdover block
`timescale 1ns/1ps
module tb_top;
  logic       clock = 1'b0, reset = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, phase_err = 8'h00;
  logic       reg_write = 1'b0, reg_read = 1'b0, ref_edge = 1'b0;
  logic       hold_req = 1'b0, resync_pin_n;
  logic       ld_cmp_in = 1'b0, ald_pulse = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] r_delay_sel, n_delay_sel;
  logic       r_cnt_reset, a_cnt_reset, b_cnt_reset, cp_high_z;
  logic       lock_indicator_pin, lock_indicator_pin_oe, ld_current_on;
  logic       status_pin, reference_monitor_pin;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  // 40 MHz clock
  always #12.5 clock = ~clock;
  // Feedback edge tied low; reference edges alone drive the detector
  pld_lock_holdover #(.CW(3)) dut_u (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .ref_edge(ref_edge),
    .fb_edge(1'b0), .phase_err(phase_err), .resync_pin_n(resync_pin_n),
    .ld_cmp_in(ld_cmp_in), .ald_pulse(ald_pulse),
    .r_cnt_reset(r_cnt_reset),
    .a_cnt_reset(a_cnt_reset), .b_cnt_reset(b_cnt_reset),
    .r_delay_sel(r_delay_sel), .n_delay_sel(n_delay_sel),
    .cp_high_z(cp_high_z), .lock_indicator_pin(lock_indicator_pin),
    .lock_indicator_pin_oe(lock_indicator_pin_oe),
    .ld_current_on(ld_current_on), .status_pin(status_pin),
    .reference_monitor_pin(reference_monitor_pin));
  pld_host_model host_u (.clock(clock), .hold_req(hold_req),
    .resync_pin_n(resync_pin_n));
  // Verdict and end of run
  task automatic summarize;
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Idle edge so a following strobe starts in a later time step
    @(posedge clock);
  endtask : wr
  // Read data stands only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clock);
  endtask : rd
  // One reference event, spaced wider than the unlock window
  task automatic ev(input logic [7:0] e);
    phase_err <= e;
    ref_edge <= 1'b1;
    @(posedge clock);
    ref_edge <= 1'b0;
    tick(3);
  endtask : ev
  task automatic pins(input logic [2:0] e);
    chk({5'h00, lock_indicator_pin, status_pin, reference_monitor_pin},
        {5'h00, e});
  endtask : pins
  task automatic t_regs;
    logic [7:0] a[6] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D};
    foreach (a[i]) rd(a[i], 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(8'h19, 8'h2B);
    rd(8'h19, 8'h2B);
    chk({5'h00, r_delay_sel}, 8'h03);
    chk({5'h00, n_delay_sel}, 8'h05);
    wr(8'h19, 8'h00);
  endtask : t_regs
  task automatic t_sync;
    hold_req <= 1'b1;
    tick(8);
    chk({5'h00, r_cnt_reset, a_cnt_reset, b_cnt_reset}, 8'h00);
    hold_req <= 1'b0;
    tick(8);
    wr(8'h19, 8'h40);
    hold_req <= 1'b1;
    tick(8);
    chk({5'h00, r_cnt_reset, a_cnt_reset, b_cnt_reset}, 8'h07);
    hold_req <= 1'b0;
    tick(8);
    chk({5'h00, r_cnt_reset, a_cnt_reset, b_cnt_reset}, 8'h00);
    wr(8'h19, 8'h00);
  endtask : t_sync
  task automatic t_lock;
    wr(8'h18, 8'h00);
    wr(8'h1A, 8'h01);
    wr(8'h1B, 8'h01);
    wr(8'h17, 8'h04);
    repeat (3) ev(8'h05);
    ev(8'h0E);
    repeat (3) ev(8'h05);
    pins(3'b000);
    ev(8'h05);
    pins(3'b111);
    ev(8'h0E);
    pins(3'b111);
    wr(8'h1A, 8'h04);
    tick(3);
    chk({6'h00, ld_current_on, lock_indicator_pin_oe}, 8'h02);
    ev(8'h20);
    chk({5'h00, ld_current_on, lock_indicator_pin_oe, status_pin},
        8'h02);
  endtask : t_lock
  task automatic t_hold;
    int i;
    wr(8'h1D, 8'h07);
    hold_req <= 1'b1;
    tick(6);
    chk({7'h00, cp_high_z}, 8'h01);
    hold_req <= 1'b0;
    tick(10);
    chk({7'h00, cp_high_z}, 8'h01);
    ref_edge <= 1'b1;
    // Bounded wait; a missing release shows up as a mismatch below
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      ref_edge <= 1'b0;
      #1 if (cp_high_z === 1'b0) break;
    end
    chk({7'h00, cp_high_z}, 8'h00);
    chk({5'h00, r_cnt_reset, a_cnt_reset, b_cnt_reset}, 8'h01);
    @(posedge clock);
    #1 chk({7'h00, b_cnt_reset}, 8'h00);
    @(posedge clock);
  endtask : t_hold
  // Analog pulse polarity, comparator routing, automatic holdover
  task automatic t_pins;
    wr(8'h1A, 8'h02);
    tick(1);
    chk({6'h00, lock_indicator_pin, lock_indicator_pin_oe}, 8'h03);
    ald_pulse <= 1'b1;
    tick(2);
    chk({6'h00, lock_indicator_pin, lock_indicator_pin_oe}, 8'h01);
    wr(8'h1A, 8'h03);
    tick(1);
    chk({6'h00, lock_indicator_pin, lock_indicator_pin_oe}, 8'h03);
    ald_pulse <= 1'b0;
    wr(8'h17, 8'h14);
    wr(8'h1B, 8'h06);
    ld_cmp_in <= 1'b1;
    tick(4);
    chk({6'h00, status_pin, reference_monitor_pin}, 8'h02);
    wr(8'h1D, 8'h05);
    ld_cmp_in <= 1'b0;
    tick(5);
    chk({7'h00, cp_high_z}, 8'h00);
    wr(8'h1D, 8'h0D);
    tick(1);
    chk({7'h00, cp_high_z}, 8'h01);
    ld_cmp_in <= 1'b1;
    tick(4);
    ref_edge <= 1'b1;
    @(posedge clock);
    ref_edge <= 1'b0;
    #1 chk({6'h00, cp_high_z, b_cnt_reset}, 8'h01);
    @(posedge clock);
    wr(8'h1D, 8'h00);
  endtask : t_pins
  // Hang guard
  initial begin
    tick(20000);
    n_mismatch++;
    summarize();
  end
  initial begin
    tick(10);
    reset <= 1'b0;
    @(posedge clock);
    t_regs();
    t_sync();
    t_lock();
    t_hold();
    t_pins();
    summarize();
  end
endmodule : tb_top
